// file: rtl/tmr8_consts.vh
// Constants for the 8-bit timer with overflow and clear-on-match modes
`ifndef TMR8_CONSTS_VH
`define TMR8_CONSTS_VH
// Register byte addresses
`define TMR8_ADDR_CTRL      8'h00
`define TMR8_ADDR_COUNT     8'h04
`define TMR8_ADDR_COMPARE   8'h08
`define TMR8_ADDR_FLAGS     8'h0C
`define TMR8_ADDR_STATUS    8'h10
// Control register fields
`define TMR8_WGM_LSB        0
`define TMR8_COM_LSB        2
`define TMR8_CS_LSB         4
`define TMR8_DIR_BIT        7
`define TMR8_OVF_IE_BIT     8
`define TMR8_CMP_IE_BIT     9
`define TMR8_FORCE_BIT      10
// Flag register fields
`define TMR8_OVF_BIT        0
`define TMR8_CMP_BIT        1
// Waveform modes
`define TMR8_WGM_NORMAL     2'h0
`define TMR8_WGM_PCPWM      2'h1
`define TMR8_WGM_CTC        2'h2
`define TMR8_WGM_FPWM       2'h3
// Compare output actions
`define TMR8_COM_OFF        2'h0
`define TMR8_COM_TOGGLE     2'h1
`define TMR8_COM_CLEAR      2'h2
`define TMR8_COM_SET        2'h3
// Clock select codes
`define TMR8_CS_STOP        3'h0
`define TMR8_CS_DIV1        3'h1
`define TMR8_CS_DIV8        3'h2
`define TMR8_CS_DIV64       3'h3
`define TMR8_CS_DIV256      3'h4
`define TMR8_CS_DIV1024     3'h5
// Counter extremes and reset values
`define TMR8_MAX            8'hFF
`define TMR8_BOTTOM         8'h00
`define TMR8_CTRL_RST       11'h000
// Bus answers
`define TMR8_RESP_OKAY      2'h0
`define TMR8_RESP_SLVERR    2'h2
`endif

// file: rtl/tmr8_top.v
// 8-bit timer/counter with overflow and clear-on-match modes, AXI4-Lite
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "tmr8_consts.vh"

module tmr8_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        overflow_ack,
  input  wire        compare_ack,
  output wire        overflow_irq,
  output wire        compare_irq,
  output reg         compare_output_pin,
  output wire        compare_output_oe
);

////////////////////////////////////////////////////////////////////////////
// State
reg  [10:0] ctrl_q;
reg  [7:0]  count_value_q;
reg  [7:0]  compare_value_q;
reg         overflow_flag_q;
reg         compare_match_flag_q;
reg         compare_output_q;
reg         block_q;
reg  [9:0]  presc_q;
reg  [7:0]  aw_addr_q;
reg         aw_have_q;
reg  [31:0] w_data_q;
reg  [3:0]  w_strb_q;
reg         w_have_q;

wire [1:0] waveform_mode_sel  = ctrl_q[`TMR8_WGM_LSB +: 2];
wire [1:0] compare_output_sel = ctrl_q[`TMR8_COM_LSB +: 2];
wire [2:0] clk_sel            = ctrl_q[`TMR8_CS_LSB +: 3];
wire       pwm_mode = waveform_mode_sel == `TMR8_WGM_PCPWM ||
                      waveform_mode_sel == `TMR8_WGM_FPWM;

////////////////////////////////////////////////////////////////////////////
// Prescaler: free-running divider, one tick per selected period
reg tick;
always @*
begin
  case (clk_sel)
    `TMR8_CS_DIV1:    tick = 1'b1;
    `TMR8_CS_DIV8:    tick = &presc_q[2:0];
    `TMR8_CS_DIV64:   tick = &presc_q[5:0];
    `TMR8_CS_DIV256:  tick = &presc_q[7:0];
    `TMR8_CS_DIV1024: tick = &presc_q[9:0];
    default:          tick = 1'b0;
  endcase
end

always @(posedge aclk)
begin
  if (!aresetn)
    presc_q <= 10'h000;
  else
    presc_q <= presc_q + 10'h001;
end

////////////////////////////////////////////////////////////////////////////
// Register bus: address and data may arrive in either order
wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
wire rd_fire = s_axi_arvalid && !s_axi_rvalid;
assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;

wire wr_ctrl  = wr_fire && aw_addr_q == `TMR8_ADDR_CTRL;
wire wr_count = wr_fire && aw_addr_q == `TMR8_ADDR_COUNT && w_strb_q[0];
wire wr_cmp   = wr_fire && aw_addr_q == `TMR8_ADDR_COMPARE && w_strb_q[0];
wire wr_flags = wr_fire && aw_addr_q == `TMR8_ADDR_FLAGS && w_strb_q[0];
wire wr_known = aw_addr_q == `TMR8_ADDR_CTRL ||
                aw_addr_q == `TMR8_ADDR_COUNT ||
                aw_addr_q == `TMR8_ADDR_COMPARE ||
                aw_addr_q == `TMR8_ADDR_FLAGS ||
                aw_addr_q == `TMR8_ADDR_STATUS;
wire force_stb = wr_ctrl && w_strb_q[1] &&
                 w_data_q[`TMR8_FORCE_BIT];
// A force written with new mode and select bits acts on the new ones,
// so one write can both set up and strike the output
wire [1:0] new_mode = w_strb_q[0] ? w_data_q[`TMR8_WGM_LSB +: 2] :
                                    waveform_mode_sel;
wire [1:0] new_sel  = w_strb_q[0] ? w_data_q[`TMR8_COM_LSB +: 2] :
                                    compare_output_sel;
wire       force_ok = force_stb && new_mode != `TMR8_WGM_PCPWM &&
                      new_mode != `TMR8_WGM_FPWM;

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    aw_have_q    <= 1'b0;
    aw_addr_q    <= 8'h00;
    w_have_q     <= 1'b0;
    w_data_q     <= 32'h00000000;
    w_strb_q     <= 4'h0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp  <= `TMR8_RESP_OKAY;
  end
  else
  begin
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_q <= 1'b1;
      aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
    if (wr_fire)
    begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? `TMR8_RESP_OKAY : `TMR8_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end
end

// Control bits are plain storage; output select acts at once
always @(posedge aclk)
begin
  if (!aresetn)
    ctrl_q <= `TMR8_CTRL_RST;
  else if (wr_ctrl)
  begin
    if (w_strb_q[0])
      ctrl_q[7:0] <= w_data_q[7:0];
    if (w_strb_q[1])
      ctrl_q[9:8] <= w_data_q[9:8];
  end
end

// No double buffer: the comparator sees a write on the next edge
always @(posedge aclk)
begin
  if (!aresetn)
    compare_value_q <= `TMR8_BOTTOM;
  else if (wr_cmp)
    compare_value_q <= w_data_q[7:0];
end

// Read data path, registered
wire [31:0] status_word = {31'h00000000, compare_output_q};
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata  <= 32'h00000000;
    s_axi_rresp  <= `TMR8_RESP_OKAY;
  end
  else if (rd_fire)
  begin
    s_axi_rvalid <= 1'b1;
    s_axi_rresp  <= `TMR8_RESP_OKAY;
    case ({s_axi_araddr[7:2], 2'b00})
      // Force bit is never stored, so it reads back as zero
      `TMR8_ADDR_CTRL:    s_axi_rdata <= {21'h000000, ctrl_q};
      `TMR8_ADDR_COUNT:   s_axi_rdata <= {24'h000000, count_value_q};
      `TMR8_ADDR_COMPARE: s_axi_rdata <= {24'h000000, compare_value_q};
      `TMR8_ADDR_FLAGS:
        s_axi_rdata <= {30'h00000000, compare_match_flag_q,
                        overflow_flag_q};
      `TMR8_ADDR_STATUS:  s_axi_rdata <= status_word;
      default:
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `TMR8_RESP_SLVERR;
      end
    endcase
  end
  else if (s_axi_rready)
    s_axi_rvalid <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////
// Counter core
// Match blocking lasts until the next timer tick, even with clock stopped
wire match   = tick && !block_q &&
               count_value_q == compare_value_q;
wire at_max  = tick && count_value_q == `TMR8_MAX;
wire ctc     = waveform_mode_sel == `TMR8_WGM_CTC;
wire ctc_clr = ctc && match;
// Overflow: count passes max to zero (CTC clear at max also wraps)
wire ovf_evt = at_max;

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    count_value_q <= `TMR8_BOTTOM;
    block_q       <= 1'b0;
  end
  else
  begin
    if (wr_count)
    begin
      count_value_q <= w_data_q[7:0];
      block_q       <= 1'b1;
    end
    else
    begin
      if (tick)
        block_q <= 1'b0;
      if (ctc_clr)
        count_value_q <= `TMR8_BOTTOM;
      else if (tick)
        // Missed tops fall through to wrap at max
        count_value_q <= count_value_q + 8'h01;
    end
  end
end

// Flags: hardware set wins over a same-cycle clear
wire ovf_clr = overflow_ack ||
               (wr_flags && w_data_q[`TMR8_OVF_BIT]);
wire cmp_clr = compare_ack ||
               (wr_flags && w_data_q[`TMR8_CMP_BIT]);
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    overflow_flag_q      <= 1'b0;
    compare_match_flag_q <= 1'b0;
  end
  else
  begin
    if (ovf_evt)
      overflow_flag_q <= 1'b1;
    else if (ovf_clr)
      overflow_flag_q <= 1'b0;
    if (match)
      compare_match_flag_q <= 1'b1;
    else if (cmp_clr)
      compare_match_flag_q <= 1'b0;
  end
end

assign overflow_irq = overflow_flag_q && ctrl_q[`TMR8_OVF_IE_BIT];
assign compare_irq  = compare_match_flag_q &&
                      ctrl_q[`TMR8_CMP_IE_BIT];

////////////////////////////////////////////////////////////////////////////
// Compare output generator
reg       cmp_out_d;
reg [1:0] act_sel;
always @*
begin
  cmp_out_d = compare_output_q;
  act_sel   = force_ok ? new_sel : compare_output_sel;
  if ((!pwm_mode && match) || force_ok)
  begin
    case (act_sel)
      `TMR8_COM_TOGGLE: cmp_out_d = !compare_output_q;
      `TMR8_COM_CLEAR:  cmp_out_d = 1'b0;
      `TMR8_COM_SET:    cmp_out_d = 1'b1;
      default:          cmp_out_d = compare_output_q;
    endcase
  end
  else if (pwm_mode && compare_output_sel[1])
  begin
    // PWM: select bit 1 enables the output, bit 0 picks polarity; match and wrap set the edges
    if (match)
      cmp_out_d = compare_output_sel[0];
    else if (at_max)
      cmp_out_d = !compare_output_sel[0];
  end
end

always @(posedge aclk)
begin
  if (!aresetn)
    compare_output_q <= 1'b0;
  else
    compare_output_q <= cmp_out_d;
end

// Pin follows the internal level in every setting; direction and select only gate the enable
always @(posedge aclk)
begin
  if (!aresetn)
    compare_output_pin <= 1'b0;
  else
    compare_output_pin <= cmp_out_d;
end
assign compare_output_oe = ctrl_q[`TMR8_DIR_BIT] &&
                           compare_output_sel != `TMR8_COM_OFF;

endmodule // tmr8_top

// file: sim/tmr8_asserts.sv
// Bus and interrupt checks for the 8-bit timer
`timescale 1ns/1ps
module tmr8_asserts (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        overflow_ack,
  input wire        compare_ack,
  input wire        overflow_irq,
  input wire        compare_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // A flag only drops on an ack or on a register write
  sequence s_clr_cause(ack);
    $past(ack) || $rose(s_axi_bvalid);
  endsequence
  // Answer shows on the same edge that the write acts on the registers
  property p_wr_ans; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_r_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_ovf_clr; $fell(overflow_irq) |-> s_clr_cause(overflow_ack);
  endproperty
  property p_cmp_clr; $fell(compare_irq) |-> s_clr_cause(compare_ack);
  endproperty
  a_wr_ans: assert property (p_wr_ans)
    else $error("write not answered");
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  a_b_hold: assert property (p_b_hold)
    else $error("write answer dropped");
  a_r_hold: assert property (p_r_hold)
    else $error("read answer dropped");
  a_w_block: assert property (p_w_block)
    else $error("write taken while answer pending");
  a_r_block: assert property (p_r_block)
    else $error("read taken while answer pending");
  a_ovf_clr: assert property (p_ovf_clr)
    else $error("overflow flag cleared by counting");
  a_cmp_clr: assert property (p_cmp_clr)
    else $error("match flag cleared by counting");
endmodule // tmr8_asserts

bind tmr8_top tmr8_asserts u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .overflow_ack(overflow_ack),
  .compare_ack(compare_ack), .overflow_irq(overflow_irq),
  .compare_irq(compare_irq)
);

// file: sim/tb_timer8_normal_ctc_modes.sv
// Self-checking bench for the 8-bit timer
`timescale 1ns/1ps
`include "tmr8_consts.vh"
`define CHK(n, e, s) begin total_checks = total_checks + 1; \
  if ((s) !== (e)) begin n_errors = n_errors + 1; \
  $display("wrong value %s exp %0h got %0h", n, e, s); end end
module tb_timer8_normal_ctc_modes;
  localparam [7:0] CT = `TMR8_ADDR_CTRL, CN = `TMR8_ADDR_COUNT;
  localparam [7:0] CP = `TMR8_ADDR_COMPARE, FL = `TMR8_ADDR_FLAGS;
  localparam [1:0] OK = `TMR8_RESP_OKAY, MC = `TMR8_WGM_CTC;
  reg         aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
  reg         bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  reg         ovf_ack = 1'h0, cmp_ack = 1'h0;
  reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
  reg  [31:0] wdata = 32'h0;
  wire        awready, wready, bvalid, arready, rvalid;
  wire        ovf_irq, cmp_irq, pin, oe;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     n_errors = 0, total_checks = 0, i, k;
  integer     nf [1:5] = '{1, 8, 64, 256, 1024};
  tmr8_top dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .overflow_ack(ovf_ack), .compare_ack(cmp_ack), .overflow_irq(ovf_irq),
    .compare_irq(cmp_irq), .compare_output_pin(pin), .compare_output_oe(oe)
  );
  ////////////////////////////////////////
  // Control word: f holds force, match ie, overflow ie, pin direction
  function [31:0] ctl(input [1:0] m, c, input [2:0] s, input [3:0] f);
    ctl = {21'h0, f, s, c, m};
  endfunction
  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    reg pa, pw;
    begin
      pa = 1'h1;
      pw = 1'h1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (pa | pw)
      begin
        @(posedge aclk);
        pa = pa & !awready;
        pw = pw & !wready;
        awvalid <= pa;
        wvalid <= pw;
      end
      do @(posedge aclk); while (bvalid !== 1'h1);
      bready <= 1'h0;
      `CHK("bresp", r, bresp)
      // Spare edge so the next request never lands on this one
      @(posedge aclk);
    end
  endtask
  task rc(input [7:0] a, input [31:0] e, input [1:0] r);
    begin
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge aclk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      do @(posedge aclk); while (rvalid !== 1'h1);
      rready <= 1'h0;
      `CHK("rresp", r, rresp)
      `CHK("rdata", e, rdata)
      @(posedge aclk);
    end
  endtask
  // Counts edges until the output level changes
  task chg;
    reg p;
    begin
      p = pin;
      k = 0;
      do
      begin
        @(posedge aclk);
        #1;
        k = k + 1;
      end
      while (pin === p && k < 9000);
    end
  endtask
  task t_bus;
    begin
      rc(CT, 32'h0, OK);
      rc(8'h14, 32'h0, `TMR8_RESP_SLVERR);
      wr(8'h14, 32'h1, `TMR8_RESP_SLVERR);
    end
  endtask
  task t_normal;
    begin
      wr(CN, 32'hFA, OK);
      rc(CN, 32'hFA, OK);
      wr(CT, ctl(`TMR8_WGM_NORMAL, 2'h0, `TMR8_CS_DIV1, 4'h2), OK);
      k = 0;
      while (ovf_irq !== 1'h1 && k < 50)
      begin
        @(posedge aclk);
        k = k + 1;
      end
      `CHK("ovf wait", 5, k)
      rc(FL, 32'h3, OK);
      ovf_ack <= 1'h1;
      @(posedge aclk);
      ovf_ack <= 1'h0;
      @(posedge aclk);
      `CHK("ovf irq", 1'h0, ovf_irq)
    end
  endtask
  task t_ctc;
    begin
      wr(CP, 32'h3, OK);
      for (i = 1; i < 6; i = i + 1)
      begin
        wr(CT, ctl(MC, `TMR8_COM_TOGGLE, i[2:0], 4'h5), OK);
        chg;
        chg;
        `CHK("half period", 4 * nf[i], k)
      end
      `CHK("oe", 1'h1, oe)
      `CHK("cmp irq", 1'h1, cmp_irq)
      wr(CT, ctl(MC, `TMR8_COM_TOGGLE, `TMR8_CS_STOP, 4'h4), OK);
      `CHK("oe", 1'h0, oe)
      cmp_ack <= 1'h1;
      @(posedge aclk);
      cmp_ack <= 1'h0;
      @(posedge aclk);
      `CHK("cmp irq", 1'h0, cmp_irq)
    end
  endtask
  task t_miss;
    begin
      wr(FL, 32'h3, OK);
      wr(CN, 32'h10, OK);
      wr(CP, 32'h05, OK);
      wr(CT, ctl(MC, 2'h0, `TMR8_CS_DIV1, 4'h0), OK);
      repeat (20) @(posedge aclk);
      rc(FL, 32'h0, OK);
      repeat (260) @(posedge aclk);
      rc(FL, 32'h3, OK);
    end
  endtask
  task t_force;
    begin
      wr(CT, 32'h0, OK);
      wr(FL, 32'h3, OK);
      wr(CP, 32'h20, OK);
      wr(CN, 32'h20, OK);
      wr(CT, ctl(2'h0, 2'h0, `TMR8_CS_DIV1, 4'h0), OK);
      repeat (4) @(posedge aclk);
      rc(FL, 32'h0, OK);
      wr(CT, 32'h0, OK);
      wr(CN, 32'h40, OK);
      wr(CT, ctl(2'h0, `TMR8_COM_SET, 3'h0, 4'h8), OK);
      rc(`TMR8_ADDR_STATUS, 32'h1, OK);
      wr(CT, ctl(2'h0, `TMR8_COM_CLEAR, 3'h0, 4'h8), OK);
      rc(`TMR8_ADDR_STATUS, 32'h0, OK);
      wr(CT, ctl(2'h0, `TMR8_COM_TOGGLE, 3'h0, 4'h8), OK);
      rc(`TMR8_ADDR_STATUS, 32'h1, OK);
      rc(FL, 32'h0, OK);
      rc(CN, 32'h40, OK);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  always #12.5 aclk = ~aclk;
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_bus;
    t_normal;
    t_ctc;
    t_miss;
    t_force;
    summarize;
  end
  // Slowest scenario is the divide-by-1024 period, far below this
  initial
  begin
    #(25 * 60000);
    n_errors = n_errors + 1;
    summarize;
  end
endmodule // tb_timer8_normal_ctc_modes
